// >>> src/usw_ctrl.sv
// Contract
// - Wire mode affects outputs and start detect; other inputs always work
// - Mode zero: outputs, hold, start detect off
// - Three-wire: shift output replaces data port bit
// - Three-wire: data in, clock pins unchanged
// - Two-wire: open-drain pins enabled by direction
// - Data pulled low on shifter or port zero
// - Clock pulled low on port zero or start
// - Start detect holds clock until flag cleared
// - Two-wire disables pull-ups on both pins
// - Mode three also holds clock after overflow
// - External clock: output changes opposite edge
// - Clock select table for strobe and timer
// - External edges shift; counter both or toggle
// - Clock strobe shifts and increments once
// - Strobe shifts in previously sampled input
// - Strobe and toggle bits read zero
// - Toggle bit inverts clock port value
// - External with strobe set: toggle counts
// - Overflow flag set on wrap to zero
// - Start flag cleared by writing one
//
// Control for the serial interface wire modes and clock sources.
// Assumes an APB master on mclk and pins resolved outside.
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ns
module usw_ctrl
(
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Timer compare match pulse, same domain
    input wire logic timer_match,
    // Start detector request, asynchronous
    input wire logic start_detect,
    // Pins: data output
    output logic do_o,
    output logic do_oe,
    output logic do_pullup,
    // Pins: data in / two-wire data
    input wire logic sdi_i,
    output logic sdi_o,
    output logic sdi_oe,
    output logic sdi_pullup,
    // Pins: clock
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe,
    output logic sck_pullup
);
    // ------------------------------------------------------------
    // Registers and synchronisers
    // ------------------------------------------------------------
    logic [7:0] ctrl_r; // Control (toggle bit never stored; strobe bit kept only with external select)
    logic [7:0] data_r; // Shift register
    logic [7:0] port_r; // Port and direction bits
    logic [3:0] cnt_r; // 4-bit counter
    logic sif_r; // Start condition flag
    logic oif_r; // Counter overflow flag
    logic do_latch_r; // Output latch
    logic [1:0] sck_s_r; // Clock pin synchroniser
    logic [1:0] sdi_s_r; // Data pin synchroniser
    logic [1:0] st_s_r; // Start detect synchroniser
    logic sck_d_r; // Previous synchronised clock
    logic st_d_r; // Previous start level
    logic sdi_prev_r; // Input sampled last cycle
    logic [31:0] prdata_r; // Read data
    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire wr = psel && penable && pwrite;
    wire rd = psel && penable && !pwrite;
    wire hit = paddr == usw_pkg::CTRL_OFS || paddr == usw_pkg::STAT_OFS
        || paddr == usw_pkg::DATA_OFS || paddr == usw_pkg::PORT_OFS;
    wire wr_ctrl = wr && paddr == usw_pkg::CTRL_OFS;
    wire wr_stat = wr && paddr == usw_pkg::STAT_OFS;
    wire wr_data = wr && paddr == usw_pkg::DATA_OFS;
    wire wr_port = wr && paddr == usw_pkg::PORT_OFS;
    wire [1:0] wm = ctrl_r[usw_pkg::WM_HI:usw_pkg::WM_LO];
    wire cs1 = ctrl_r[usw_pkg::CS_HI];
    wire cs0 = ctrl_r[usw_pkg::CS_LO];
    wire clk_sel = ctrl_r[usw_pkg::CLK_BIT]; // Stored for external select
    wire two_wire = wm[1];
    wire strobe_w = wr_ctrl && pwdata[usw_pkg::CLK_BIT];
    wire toggle_w = wr_ctrl && pwdata[usw_pkg::TC_BIT];
    // Edges on synchronised clock pin, usable in any mode
    wire sck_s = sck_s_r[1];
    wire sck_rise = sck_s && !sck_d_r;
    wire sck_fall = !sck_s && sck_d_r;
    wire start_ev = st_s_r[1] && !st_d_r && two_wire;
    // Clock source decode
    wire sw_clk = !cs1 && !cs0 && strobe_w;
    wire tm_clk = !cs1 && cs0 && timer_match;
    wire ext_sh = cs1 && (cs0 ? sck_fall : sck_rise);
    wire ext_cnt = cs1 && (clk_sel ? toggle_w : (sck_rise || sck_fall));
    wire shift_en = sw_clk || tm_clk || ext_sh;
    wire cnt_en = sw_clk || tm_clk || ext_cnt;
    wire wrap = cnt_en && cnt_r == usw_pkg::CNT_MAX;
    // Sample: strobe uses previous cycle, others current
    wire shift_in = sw_clk ? sdi_prev_r : sdi_s_r[1];
    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            sck_s_r <= 2'h0;
            sdi_s_r <= 2'h0;
            st_s_r <= 2'h0;
            sck_d_r <= 1'b0;
            st_d_r <= 1'b0;
            sdi_prev_r <= 1'b0;
        end
        else
        begin
            sck_s_r <= {sck_s_r[0], sck_i};
            sdi_s_r <= {sdi_s_r[0], sdi_i};
            st_s_r <= {st_s_r[0], start_detect};
            sck_d_r <= sck_s_r[1];
            st_d_r <= st_s_r[1];
            sdi_prev_r <= sdi_s_r[1];
        end
    end
    // ------------------------------------------------------------
    // Control and port registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl_r <= usw_pkg::CTRL_RST;
            port_r <= usw_pkg::PORT_RST;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_r <= {pwdata[7:2], pwdata[usw_pkg::CLK_BIT] & pwdata[usw_pkg::CS_HI], 1'b0};
            // Toggle inverts clock port bit regardless of direction
            if (wr_port)
                port_r <= pwdata[7:0];
            else if (toggle_w)
                port_r[usw_pkg::PCK_BIT] <= !port_r[usw_pkg::PCK_BIT];
        end
    end
    // ------------------------------------------------------------
    // Shift register and counter; a write wins over a shift
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            data_r <= usw_pkg::DATA_RST;
            cnt_r <= usw_pkg::CNT_RST;
        end
        else
        begin
            if (wr_data)
                data_r <= pwdata[7:0];
            else if (shift_en)
                data_r <= {data_r[6:0], shift_in};
            if (wr_stat)
                cnt_r <= pwdata[3:0];
            else if (cnt_en)
                cnt_r <= cnt_r + 4'h1;
        end
    end
    // ------------------------------------------------------------
    // Flags: set wins over a write-one clear
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            sif_r <= 1'b0;
            oif_r <= 1'b0;
        end
        else
        begin
            if (start_ev)
                sif_r <= 1'b1;
            else if (wr_stat && pwdata[usw_pkg::SIF_BIT])
                sif_r <= 1'b0;
            if (wrap)
                oif_r <= 1'b1;
            else if (wr_stat && pwdata[usw_pkg::OIF_BIT])
                oif_r <= 1'b0;
        end
    end
    // ------------------------------------------------------------
    // Output latch: external clock updates on the low phase (select 10) or the high phase (select 11)
    // ------------------------------------------------------------
    wire latch_open = !cs1 || (cs0 ? sck_s : !sck_s);
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            do_latch_r <= 1'b0;
        else if (latch_open)
            do_latch_r <= data_r[7];
    end
    // Transparent for internal sources, so the MSB passes at once
    wire msb_out = !cs1 ? data_r[7] : do_latch_r;
    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    wire hold = (sif_r && two_wire) || (oif_r && wm == 2'h3);
    wire tw_sda_low = !(msb_out && port_r[usw_pkg::PDI_BIT]);
    wire tw_scl_low = !port_r[usw_pkg::PCK_BIT] || hold;
    always_comb
    begin
        // Plain port behaviour by default
        do_o = port_r[usw_pkg::PDO_BIT];
        do_oe = port_r[usw_pkg::DDO_BIT];
        do_pullup = !port_r[usw_pkg::DDO_BIT] && port_r[usw_pkg::PDO_BIT];
        sdi_o = port_r[usw_pkg::PDI_BIT];
        sdi_oe = port_r[usw_pkg::DDI_BIT];
        sdi_pullup = !port_r[usw_pkg::DDI_BIT] && port_r[usw_pkg::PDI_BIT];
        sck_o = port_r[usw_pkg::PCK_BIT];
        sck_oe = port_r[usw_pkg::DCK_BIT];
        sck_pullup = !port_r[usw_pkg::DCK_BIT] && port_r[usw_pkg::PCK_BIT];
        if (wm == 2'h1)
            do_o = msb_out;
        if (two_wire)
        begin
            // Open drain: drive only low, pull-ups off
            sdi_o = 1'b0;
            sdi_oe = port_r[usw_pkg::DDI_BIT] && tw_sda_low;
            sck_o = 1'b0;
            sck_oe = port_r[usw_pkg::DCK_BIT] && tw_scl_low;
            sdi_pullup = 1'b0;
            sck_pullup = 1'b0;
        end
    end
    // ------------------------------------------------------------
    // Read back; strobe bits read zero
    // ------------------------------------------------------------
    wire [7:0] stat_v = {sif_r, oif_r, 2'h0, cnt_r};
    wire [7:0] rd_v = paddr == usw_pkg::CTRL_OFS ? {ctrl_r[7:2], 2'h0}
        : paddr == usw_pkg::STAT_OFS ? stat_v
        : paddr == usw_pkg::DATA_OFS ? data_r
        : paddr == usw_pkg::PORT_OFS ? port_r : 8'h00;
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            prdata_r <= 32'h0;
        else if (psel && !penable && !pwrite)
            prdata_r <= {24'h0, rd_v};
    end
    assign prdata = prdata_r;
    assign pready = 1'b1;
    assign pslverr = (wr || rd) && !hit;
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence strobe_s;
        !cs1 && !cs0 && wr_ctrl && pwdata[usw_pkg::CLK_BIT] && !wr_stat;
    endsequence
    strobe_cnt_a: assert property (@(posedge mclk) disable iff (!resetn)
        strobe_s |=> cnt_r == $past(cnt_r) + 4'h1)
        else $error("strobe did not count");
    wrap_flag_a: assert property (@(posedge mclk) disable iff (!resetn)
        wrap |=> oif_r) else $error("overflow flag not set");
    hold_sif_a: assert property (@(posedge mclk) disable iff (!resetn)
        sif_r && two_wire && port_r[usw_pkg::DCK_BIT] |-> sck_oe && !sck_o)
        else $error("clock not held on start");
    hold_oif_a: assert property (@(posedge mclk) disable iff (!resetn)
        oif_r && wm == 2'h3 && port_r[usw_pkg::DCK_BIT] |-> sck_oe)
        else $error("clock not held on overflow");
    pullup_off_a: assert property (@(posedge mclk) disable iff (!resetn)
        two_wire |-> !sdi_pullup && !sck_pullup) else $error("pull-up in two-wire");
    toggle_inv_a: assert property (@(posedge mclk) disable iff (!resetn)
        toggle_w && !wr_port |=> port_r[usw_pkg::PCK_BIT] != $past(port_r[usw_pkg::PCK_BIT]))
        else $error("toggle did not invert");
    off_mode_a: assert property (@(posedge mclk) disable iff (!resetn)
        wm == 2'h0 |-> do_o == port_r[usw_pkg::PDO_BIT] && !start_ev)
        else $error("mode zero not plain");
    three_out_a: assert property (@(posedge mclk) disable iff (!resetn)
        wm == 2'h1 && !cs1 |-> do_o == data_r[7]) else $error("data out not shifter");
    sif_clear_a: assert property (@(posedge mclk) disable iff (!resetn)
        sif_r && !(wr_stat && pwdata[usw_pkg::SIF_BIT]) |=> sif_r)
        else $error("start flag lost");
    rd_zero_a: assert property (@(posedge mclk) disable iff (!resetn)
        psel && penable && !pwrite && paddr == usw_pkg::CTRL_OFS |-> prdata[1:0] == 2'h0)
        else $error("strobe bits read nonzero");
    // ------------------------------------------------------------
    // Assertions: clock sources
    // ------------------------------------------------------------
    // Timer match with select 01 counts once
    sequence tm_s;
        !cs1 && cs0 && timer_match && !wr_stat;
    endsequence
    tm_count_a: assert property (@(posedge mclk) disable iff (!resetn)
        tm_s |=> cnt_r == $past(cnt_r) + 4'h1)
        else $error("timer match did not count");
    // Select 00 without strobe leaves the counter alone
    no_clock_a: assert property (@(posedge mclk) disable iff (!resetn)
        !cs1 && !cs0 && !strobe_w && !wr_stat |=> $stable(cnt_r))
        else $error("counter moved without clock");
    // External select: either pin edge counts once
    sequence ext_edge_s;
        cs1 && !clk_sel && (sck_rise || sck_fall) && !wr_stat;
    endsequence
    ext_both_a: assert property (@(posedge mclk) disable iff (!resetn)
        ext_edge_s |=> cnt_r == $past(cnt_r) + 4'h1)
        else $error("external edge did not count");
    // Toggle strobe counts when the strobe bit selects it
    sequence tc_s;
        cs1 && clk_sel && toggle_w && !wr_stat;
    endsequence
    tc_count_a: assert property (@(posedge mclk) disable iff (!resetn)
        tc_s |=> cnt_r == $past(cnt_r) + 4'h1)
        else $error("toggle strobe did not count");
    // Latch stays shut through the sampling half
    latch_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
        cs1 && !latch_open |=> $stable(do_latch_r))
        else $error("output latch moved while shut");
    // ------------------------------------------------------------
    // Assertions: pins
    // ------------------------------------------------------------
    // Three-wire leaves the clock pin as a plain port
    three_pins_a: assert property (@(posedge mclk) disable iff (!resetn)
        wm == 2'h1 |-> sck_o == port_r[usw_pkg::PCK_BIT]
            && sck_oe == port_r[usw_pkg::DCK_BIT])
        else $error("three-wire clock pin not plain");
    // Two-wire drives only low, gated by direction bits
    two_pins_a: assert property (@(posedge mclk) disable iff (!resetn)
        two_wire |-> !sdi_o && !sck_o && (!sdi_oe || port_r[usw_pkg::DDI_BIT])
            && (!sck_oe || port_r[usw_pkg::DCK_BIT]))
        else $error("two-wire drive not open drain");
    // Data line low on shifter or port zero, else released
    sda_low_a: assert property (@(posedge mclk) disable iff (!resetn)
        two_wire && port_r[usw_pkg::DDI_BIT]
            |-> sdi_oe == !(msb_out && port_r[usw_pkg::PDI_BIT]))
        else $error("data line drive wrong");
    // Clock line low while its port bit is zero
    scl_low_a: assert property (@(posedge mclk) disable iff (!resetn)
        two_wire && port_r[usw_pkg::DCK_BIT] && !port_r[usw_pkg::PCK_BIT] |-> sck_oe)
        else $error("clock line not pulled low");
endmodule // usw_ctrl

// >>> src/usw_pkg.sv
// Package for the serial wire and clock control block.
// Assumes an APB slave with 32-bit data and byte addresses.
package usw_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00; // Control register
    localparam logic [7:0] STAT_OFS = 8'h04; // Status: flags and counter
    localparam logic [7:0] DATA_OFS = 8'h08; // Shift register
    localparam logic [7:0] PORT_OFS = 8'h0C; // Port and direction bits
    // ------------------------------------------------------------
    // Control field positions
    // ------------------------------------------------------------
    localparam int WM_HI = 5;  // Wire mode field high bit
    localparam int WM_LO = 4;  // Wire mode field low bit
    localparam int CS_HI = 3;  // Clock source select high bit
    localparam int CS_LO = 2;  // Clock source select low bit
    localparam int CLK_BIT = 1; // Clock strobe bit
    localparam int TC_BIT = 0;  // Toggle clock bit
    // Status field positions
    localparam int SIF_BIT = 7; // Start condition flag
    localparam int OIF_BIT = 6; // Counter overflow flag
    // Port register positions
    localparam int PDO_BIT = 0; // Data output port bit
    localparam int PDI_BIT = 1; // Data in pin port bit
    localparam int PCK_BIT = 2; // Clock pin port bit
    localparam int DDO_BIT = 4; // Data output direction bit
    localparam int DDI_BIT = 5; // Data in pin direction bit
    localparam int DCK_BIT = 6; // Clock pin direction bit
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] PORT_RST = 8'h00;
    localparam logic [3:0] CNT_RST = 4'h0;
    localparam logic [3:0] CNT_MAX = 4'hF; // Counter wraps after this
    // Wire modes
    typedef enum logic [1:0] {WM_OFF, WM_THREE, WM_TWO, WM_TWO_HOLD} usw_wm_t;
endpackage

// >>> test/usi_wire_and_clock_control_bench.sv
// Self-checking bench for the serial wire and clock control block.
// Assumes usw_pkg and usw_ctrl compiled first; peer model beside the pins.
`timescale 1ns/1ns
module usi_wire_and_clock_control_bench;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    typedef struct {logic [31:0] v; logic [31:0] m; logic e;} usw_note_t;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, timer_match = 1'b0, start_detect = 1'b0;
    logic do_o, do_oe, do_pullup, sdi_o, sdi_oe, sdi_pullup;
    logic sck_o, sck_oe, sck_pullup, sck_line, sdi_line;
    logic [7:0] ofs [4] = '{usw_pkg::CTRL_OFS, usw_pkg::STAT_OFS,
                            usw_pkg::DATA_OFS, usw_pkg::PORT_OFS};
    usw_note_t notes [$]; // Expected reads, oldest first
    usw_note_t nt;
    int n_errors = 0;
    int check_count = 0;
    logic [7:0] r;
    logic b;
    // ------------------------------------------------------------
    // Design, peer and clock
    // ------------------------------------------------------------
    usw_ctrl u_dut (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer_match(timer_match),
        .start_detect(start_detect), .do_o(do_o), .do_oe(do_oe),
        .do_pullup(do_pullup), .sdi_i(sdi_line), .sdi_o(sdi_o), .sdi_oe(sdi_oe),
        .sdi_pullup(sdi_pullup), .sck_i(sck_line), .sck_o(sck_o),
        .sck_oe(sck_oe), .sck_pullup(sck_pullup));
    usw_peer u_peer (.dev_sck_o(sck_o), .dev_sck_oe(sck_oe), .dev_sdi_o(sdi_o),
        .dev_sdi_oe(sdi_oe), .sck_line(sck_line), .sdi_line(sdi_line));
    initial
    begin
        forever #5 mclk = ~mclk;
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Count one compare, report a miss
    task automatic chk(input logic ok, input string what);
        check_count++;
        if (ok !== 1'b1)
        begin
            n_errors++;
            $display("[ERR] %0t %s", $time, what);
        end
    endtask
    // One APB transfer: setup, then access until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++)
        begin
            @(posedge mclk);
            if (pready === 1'b1)
                break;
        end
        if (n == 16)
        begin
            chk(1'b0, "bus timeout");
            report_and_stop();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input int i, input logic [31:0] d);
        apb(1'b1, ofs[i], d);
    endtask
    // Read with an expected value noted for the monitor
    task automatic rd(input int i, input logic [31:0] v, input logic [31:0] m);
        notes.push_back('{v, m, 1'b0});
        apb(1'b0, ofs[i], 32'h0);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // Timer compare pulses, one cycle each
    task automatic tick(input int k);
        repeat (k)
        begin
            @(posedge mclk);
            timer_match <= 1'b1;
            @(posedge mclk);
            timer_match <= 1'b0;
        end
    endtask
    // Monitor: completed reads against the oldest note
    always @(posedge mclk)
        if (psel && penable && pready === 1'b1 && !pwrite)
        begin
            nt = notes.pop_front();
            chk(((prdata & nt.m) === nt.v) && (pslverr === nt.e), "read mismatch");
        end
    // Hang guard
    initial
    begin
        #1000000;
        chk(1'b0, "run timeout");
        report_and_stop();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(14));
        r = 8'($urandom());
        b = 1'($urandom());
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        // Reset values, then an unmapped address
        for (int i = 0; i < 4; i++) rd(i, 32'h0, 32'hFFFFFFFF);
        notes.push_back('{32'h0, 32'hFFFFFFFF, 1'b1});
        apb(1'b0, 8'h10, 32'h0);
        // Software strobe wraps counter 14 to 0
        u_peer.put_data(b);
        wr(1, 32'h0E);
        wr(2, {24'h0, r});
        wr(0, 32'h02);
        wr(0, 32'h03);
        rd(0, 32'h0, 32'hFFFFFFFF);
        rd(1, 32'h40, 32'hFFFFFFFF);
        rd(2, {24'h0, r[5:0], b, b}, 32'hFF);
        rd(3, 32'h04, 32'h04);
        wr(1, 32'h40);
        rd(1, 32'h0, 32'h40);
        // Timer clocking only with select 01
        wr(0, 32'h0);
        tick(2);
        wr(0, 32'h04);
        tick(5);
        rd(1, 32'h5, 32'hF);
        // Toggle strobe counts with external select
        wr(1, 32'h0);
        wr(0, 32'h0A);
        repeat (3) wr(0, 32'h0B);
        rd(1, 32'h3, 32'hF);
        rd(3, 32'h0, 32'h04);
        // External clock, both edge polarities, outputs off
        for (int k = 0; k < 2; k++)
        begin
            wr(0, k ? 32'h0C : 32'h08);
            wr(1, 32'h0);
            wr(2, 32'h0);
            u_peer.send_bits(3, 8'h05);
            cyc(8);
            rd(1, 32'h6, 32'hF);
            rd(2, 32'h5, 32'hFF);
        end
        // Data output pin by wire mode
        wr(3, 32'h10);
        wr(2, 32'h80);
        wr(0, 32'h0);
        cyc(2);
        chk(do_o === 1'b0, "off mode data pin");
        wr(0, 32'h10);
        cyc(2);
        chk(do_o === 1'b1 && do_oe === 1'b1, "three-wire data pin");
        // Input direction: port bit keeps the pull-up, other pins plain
        wr(3, 32'h47);
        cyc(2);
        chk(do_oe === 1'b0 && do_pullup === 1'b1, "three-wire pull-up");
        chk(sck_o === 1'b1 && sck_oe === 1'b1, "three-wire clock pin");
        chk(sdi_oe === 1'b0 && sdi_pullup === 1'b1, "three-wire data in pin");
        // Two-wire open-drain pins; pull-up requested by port bit first
        wr(0, 32'h20);
        cyc(2);
        chk(sdi_pullup === 1'b0 && sck_pullup === 1'b0, "pull-ups on");
        wr(3, 32'h66);
        cyc(2);
        chk(sdi_oe === 1'b0 && sck_oe === 1'b0, "two-wire release");
        wr(2, 32'h0);
        cyc(2);
        chk(sdi_oe === 1'b1 && sdi_o === 1'b0, "data not pulled");
        wr(3, 32'h62);
        cyc(2);
        chk(sck_oe === 1'b1 && sck_o === 1'b0, "clock not pulled");
        wr(3, 32'h66);
        // Start condition holds the clock until cleared
        @(posedge mclk);
        start_detect <= 1'b1;
        cyc(6);
        chk(sck_oe === 1'b1, "start hold missing");
        rd(1, 32'h80, 32'h80);
        wr(1, 32'h80);
        cyc(2);
        chk(sck_oe === 1'b0, "start hold stuck");
        @(posedge mclk);
        start_detect <= 1'b0;
        // Overflow hold in mode three
        wr(1, 32'h0F);
        wr(0, 32'h32);
        cyc(2);
        chk(sck_oe === 1'b1, "overflow hold missing");
        wr(1, 32'h40);
        cyc(2);
        chk(sck_oe === 1'b0, "overflow hold stuck");
        cyc(4);
        report_and_stop();
    end
endmodule // usi_wire_and_clock_control_bench

// >>> test/usw_peer.sv
// Far-side serial peer: open-drain clock and data lines with pull-ups.
// Assumes the device's pin enables mean drive; released lines float high.
`timescale 1ns/1ns
module usw_peer
(
    // Device pin drives
    input wire logic dev_sck_o,
    input wire logic dev_sck_oe,
    input wire logic dev_sdi_o,
    input wire logic dev_sdi_oe,
    // Resolved line levels
    output logic sck_line,
    output logic sdi_line
);
    // ------------------------------------------------------------
    // Line state
    // ------------------------------------------------------------
    logic sck_low = 1'b1; // Clock parked low between frames
    logic sda_low = 1'b0; // Data released by default
    // Device drive wins, else peer pull-down, else pull-up
    assign sck_line = dev_sck_oe ? dev_sck_o : ~sck_low;
    assign sdi_line = dev_sdi_oe ? dev_sdi_o : ~sda_low;
    // Set the data line outside a frame
    task automatic put_data(input logic b);
        sda_low = ~b;
    endtask
    // One frame of clock pulses, 125 ns each, MSB first
    task automatic send_bits(input int n, input logic [7:0] bits);
        int w;
        for (int i = n - 1; i >= 0; i--)
        begin
            sda_low = ~bits[i];
            #31;
            sck_low = 1'b0;
            // Wait while the device stretches the clock
            for (w = 0; w < 100 && sck_line !== 1'b1; w++) #10;
            #63;
            sck_low = 1'b1;
            #31;
        end
    endtask
endmodule // usw_peer
